/* hdl/csb_pkg.sv */
// Purpose: Shared constants and types for the core special function register bank
// Assumes: Register indices are byte addresses divided by four on the bus
// Notes: Offsets are register indices; bus byte address is four times the index
package csb_pkg;
  localparam int unsigned IDX_W = 8;
  localparam logic [IDX_W-1:0] IDX_STACK_PTR = 8'h81;
  localparam logic [IDX_W-1:0] IDX_ACTIVE_DATA_POINTER_LOW = 8'h82;
  localparam logic [IDX_W-1:0] IDX_ACTIVE_DATA_POINTER_HIGH = 8'h83;
  localparam logic [IDX_W-1:0] IDX_ALT_LOW = 8'h84;
  localparam logic [IDX_W-1:0] IDX_ALT_HIGH = 8'h85;
  localparam logic [IDX_W-1:0] IDX_CORE_MODE = 8'h87;
  localparam logic [IDX_W-1:0] IDX_WAIT_CTRL = 8'h8e;
  localparam logic [IDX_W-1:0] IDX_PTR_SELECT = 8'h92;
  localparam logic [IDX_W-1:0] IDX_SOFT_RESET = 8'hf7;

  localparam logic [7:0] RST_STACK_PTR = 8'h00;
  localparam logic [15:0] RST_ACTIVE_DATA_POINTER = 16'h0000;
  localparam logic [7:0] RST_CORE_MODE = 8'h08;
  localparam logic [7:0] RST_WAIT_CTRL = 8'h71;
  localparam logic RST_PTR_SELECT = 1'b0;

  // Core mode field positions
  localparam int unsigned MODE_BAUD_BIT = 7;
  localparam int unsigned MODE_INT_TEST_BIT = 5;
  localparam int unsigned MODE_XMOVE_CODE_BIT = 4;
  localparam int unsigned MODE_FIXED_ONE_BIT = 3;
  localparam int unsigned MODE_GEN_FLAG_BIT = 2;
  // Wait control field positions
  localparam int unsigned WAIT_PROG_LSB = 4;
  localparam int unsigned WAIT_DATA_LSB = 0;
  localparam int unsigned WAIT_FIELD_W = 3;
  localparam int unsigned PTR_SELECT_BIT = 0;
  localparam int unsigned SOFT_REQ_BIT = 0;

  localparam int unsigned NUM_VECTORS = 4;
  localparam int unsigned DUR_W = 8;
  localparam logic [2:0] MIN_FETCH_BYTES = 3'h2;

  typedef struct packed {
    logic [2:0] bytes;
    logic [3:0] cycles;
    logic is_ext_move;
    logic is_code_move;
  } csb_instr_s;

  typedef enum logic [1:0] {
    CSB_ARM_IDLE,
    CSB_ARM_PENDING,
    CSB_ARM_ARMED
  } csb_arm_e;
endpackage

/* hdl/csb_sfr_bank.sv */
// Purpose: Stack pointer, data pointers, core mode, wait control and soft reset registers
// Assumes: Avalon-MM slave, one wait cycle per access; sequencer strobes are on CLK_IN
// Notes: Sequencer updates win over bus writes to the same register in one cycle
// Notes on behaviour
// RULE_01 - Stack pointer at 0x81 increments before a push or call writes the stack.
// RULE_02 - Stack pointer decrements after a pop or return has read the stack.
// RULE_03 - Primary pointer: high byte is bits 15:8, low byte at 0x82 bits 7:0.
// RULE_04 - Each pointer works as one 16-bit register or two 8-bit registers.
// RULE_05 - Active pointer supplies indirect address for external, code moves and jumps.
// RULE_06 - Second pointer: low byte at 0x84, high byte at 0x85.
// RULE_07 - Select register 0x92 bit 0 picks the pointer; bits 7:1 unused.
// RULE_08 - Core mode register 0x87 resets to 0x08; bits 6 and 3 unused.
// RULE_09 - Core mode bit 7 holds serial port 0 baud select, driven out.
// RULE_10 - Core mode bit 5 set routes timer and serial vectors from external inputs only.
// RULE_11 - Core mode bit 4 steers external moves to code space when 1.
// RULE_12 - Core mode bit 2 is a general flag keeping whatever is written.
// RULE_13 - Core mode bits 1 and 0 read zero; software keeps them cleared.
// RULE_14 - Wait control 0x8E resets to 0x71; software keeps bits 7 and 3 set.
// RULE_15 - Wait bits 6:4 give program memory wait states per access.
// RULE_16 - Wait bits 2:0 give stretch cycles per external data access.
// RULE_17 - Writing 0, or a single 1, to reset request bit does nothing.
// RULE_18 - Writing 1 in two consecutive instructions fires a software reset.
// RULE_19 - Reading the request bit returns 1 after software reset, else 0; code also returns 1 after a later reset without a hardware cause.
// RULE_20 - Duration adds program waits per fetched byte and data stretch for external moves.
// RULE_21 - Armed state clears unless the very next instruction writes 1 again.
module csb_sfr_bank (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic HW_RESET_CAUSE_IN,
  input wire logic [9:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [3:0] AVS_BYTEENABLE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT,
  input wire logic STACK_PUSH_IN,
  input wire logic STACK_POP_IN,
  output logic [7:0] STACK_PTR_OUT,
  input wire logic ACTIVE_DATA_POINTER_WRITE_IN,
  input wire logic [15:0] ACTIVE_DATA_POINTER_WDATA_IN,
  output logic [15:0] ACTIVE_ACTIVE_DATA_POINTER_OUT,
  input wire logic INSTR_END_IN,
  input wire logic INSTR_START_IN,
  input wire csb_pkg::csb_instr_s INSTR_DESC_IN,
  output logic [csb_pkg::DUR_W-1:0] DURATION_OUT,
  output logic DURATION_VALID_OUT,
  output logic BAUD_SELECT_OUT,
  output logic EXT_MOVE_CODE_SPACE_OUT,
  output logic GENERAL_FLAG_OUT,
  output logic [2:0] PROG_WAIT_STATES_OUT,
  output logic [2:0] DATA_STRETCH_CYCLES_OUT,
  input wire logic [csb_pkg::NUM_VECTORS-1:0] INTERNAL_TRIG_IN,
  input wire logic [csb_pkg::NUM_VECTORS-1:0] EXTERNAL_TRIG_IN,
  output logic [csb_pkg::NUM_VECTORS-1:0] VECTOR_TRIG_OUT,
  output logic SOFT_RESET_OUT
);

  logic ack_ff;
  logic [7:0] stack_ptr_ff;
  logic [15:0] dptr0_ff;
  logic [15:0] dptr1_ff;
  logic ptr_select_ff;
  logic [7:0] core_mode_ff;
  logic [7:0] wait_ctrl_ff;
  csb_pkg::csb_arm_e arm_state_ff;
  csb_pkg::csb_arm_e nxt_arm_state;
  logic soft_fire_ff;
  logic soft_fired_ff;
  logic reset_src_ff;
  logic [csb_pkg::NUM_VECTORS-1:0] ext_sync1_ff;
  logic [csb_pkg::NUM_VECTORS-1:0] ext_sync2_ff;
  logic [csb_pkg::NUM_VECTORS-1:0] vector_ff;
  logic [csb_pkg::DUR_W-1:0] duration_ff;
  logic duration_valid_ff;
  logic [31:0] readdata_ff;

  logic [csb_pkg::IDX_W-1:0] bus_idx;
  logic bus_wr;
  logic [7:0] bus_byte;
  logic soft_req_write;
  logic bus_req;

  // Write a whole 8-bit register only when lane 0 is enabled
  function automatic logic hit(input logic [csb_pkg::IDX_W-1:0] idx);
    hit = bus_wr && AVS_BYTEENABLE_IN[0] && (bus_idx == idx);
  endfunction

  function automatic logic [csb_pkg::DUR_W-1:0] instr_duration(
    input csb_pkg::csb_instr_s d,
    input logic [2:0] prog_ws,
    input logic [2:0] data_ws
  );
    logic [3:0] fetches;
    logic [csb_pkg::DUR_W-1:0] sum;
    fetches = 4'h0;
    sum = '0;
    // Single-byte multi-cycle instructions still pay for two fetches
    if ((d.bytes > 3'h1) || (d.cycles == 4'h1)) begin
      fetches = {1'b0, d.bytes};
    end else begin
      fetches = {1'b0, csb_pkg::MIN_FETCH_BYTES};
    end
    fetches = fetches + {3'h0, d.is_code_move};
    sum = {4'h0, d.cycles} + csb_pkg::DUR_W'(fetches * prog_ws); // RULE_20
    if (d.is_ext_move) begin
      sum = sum + {5'h00, data_ws}; // RULE_20
    end
    instr_duration = sum;
  endfunction

  assign bus_idx = AVS_ADDRESS_IN[9:2];
  assign bus_byte = AVS_WRITEDATA_IN[7:0];
  // Writes land at the edge where waitrequest is seen low
  assign bus_req = AVS_READ_IN || AVS_WRITE_IN;
  assign bus_wr = AVS_WRITE_IN && ack_ff;
  assign AVS_WAITREQUEST_OUT = bus_req && !ack_ff;
  assign soft_req_write = hit(csb_pkg::IDX_SOFT_RESET) && bus_byte[csb_pkg::SOFT_REQ_BIT];

  // Bus handshake: one wait cycle for every access
  // A request still high after its accept edge is a fresh access and waits again
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      ack_ff <= 1'b0;
    end else if (bus_req && !ack_ff) begin
      ack_ff <= 1'b1;
    end else begin
      ack_ff <= 1'b0;
    end
  end

  // Captured in the wait cycle so the data already stands when waitrequest drops
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      readdata_ff <= 32'h0000_0000;
    end else if (AVS_READ_IN && !ack_ff) begin
      case (bus_idx)
        csb_pkg::IDX_STACK_PTR: readdata_ff <= {24'h000000, stack_ptr_ff};
        csb_pkg::IDX_ACTIVE_DATA_POINTER_LOW: readdata_ff <= {24'h000000, dptr0_ff[7:0]}; // RULE_04
        csb_pkg::IDX_ACTIVE_DATA_POINTER_HIGH: readdata_ff <= {24'h000000, dptr0_ff[15:8]};
        csb_pkg::IDX_ALT_LOW: readdata_ff <= {24'h000000, dptr1_ff[7:0]};
        csb_pkg::IDX_ALT_HIGH: readdata_ff <= {24'h000000, dptr1_ff[15:8]};
        csb_pkg::IDX_CORE_MODE: readdata_ff <= {24'h000000, core_mode_ff};
        csb_pkg::IDX_WAIT_CTRL: readdata_ff <= {24'h000000, wait_ctrl_ff};
        csb_pkg::IDX_PTR_SELECT: readdata_ff <= {31'h0000_0000, ptr_select_ff}; // RULE_07
        csb_pkg::IDX_SOFT_RESET: readdata_ff <= {31'h0000_0000, reset_src_ff}; // RULE_19
        default: readdata_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign AVS_READDATA_OUT = readdata_ff;

  // Stack pointer: push bumps it before the stack write, pop after the read
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      stack_ptr_ff <= csb_pkg::RST_STACK_PTR;
    end else if (STACK_PUSH_IN && !STACK_POP_IN) begin
      stack_ptr_ff <= stack_ptr_ff + 8'h01; // RULE_01
    end else if (STACK_POP_IN && !STACK_PUSH_IN) begin
      stack_ptr_ff <= stack_ptr_ff - 8'h01; // RULE_02
    end else if (hit(csb_pkg::IDX_STACK_PTR)) begin
      stack_ptr_ff <= bus_byte;
    end
  end
  assign STACK_PTR_OUT = stack_ptr_ff;

  // A 16-bit load from the sequencer wins over a byte write in the same cycle
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      dptr0_ff <= csb_pkg::RST_ACTIVE_DATA_POINTER;
    end else if (ACTIVE_DATA_POINTER_WRITE_IN && !ptr_select_ff) begin
      dptr0_ff <= ACTIVE_DATA_POINTER_WDATA_IN; // RULE_04
    end else begin
      if (hit(csb_pkg::IDX_ACTIVE_DATA_POINTER_LOW)) begin
        dptr0_ff[7:0] <= bus_byte; // RULE_03
      end
      if (hit(csb_pkg::IDX_ACTIVE_DATA_POINTER_HIGH)) begin
        dptr0_ff[15:8] <= bus_byte; // RULE_03
      end
    end
  end

  // Second pointer is loaded whole only while it is the selected one
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      dptr1_ff <= csb_pkg::RST_ACTIVE_DATA_POINTER;
    end else if (ACTIVE_DATA_POINTER_WRITE_IN && ptr_select_ff) begin
      dptr1_ff <= ACTIVE_DATA_POINTER_WDATA_IN; // RULE_04
    end else begin
      if (hit(csb_pkg::IDX_ALT_LOW)) begin
        dptr1_ff[7:0] <= bus_byte; // RULE_06
      end
      if (hit(csb_pkg::IDX_ALT_HIGH)) begin
        dptr1_ff[15:8] <= bus_byte; // RULE_06
      end
    end
  end

  // Only bit 0 is kept; the other select bits read as zero
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      ptr_select_ff <= csb_pkg::RST_PTR_SELECT;
    end else if (hit(csb_pkg::IDX_PTR_SELECT)) begin
      ptr_select_ff <= bus_byte[csb_pkg::PTR_SELECT_BIT]; // RULE_07
    end
  end
  assign ACTIVE_ACTIVE_DATA_POINTER_OUT = ptr_select_ff ? dptr1_ff : dptr0_ff; // RULE_05

  // Core mode: unused bit 3 reads as its reset one, bits 6, 1 and 0 as zero
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      core_mode_ff <= csb_pkg::RST_CORE_MODE; // RULE_08
    end else if (hit(csb_pkg::IDX_CORE_MODE)) begin
      core_mode_ff <= 8'h00; // RULE_13
      core_mode_ff[csb_pkg::MODE_BAUD_BIT] <= bus_byte[csb_pkg::MODE_BAUD_BIT]; // RULE_09
      core_mode_ff[csb_pkg::MODE_INT_TEST_BIT] <= bus_byte[csb_pkg::MODE_INT_TEST_BIT];
      core_mode_ff[csb_pkg::MODE_XMOVE_CODE_BIT] <= bus_byte[csb_pkg::MODE_XMOVE_CODE_BIT];
      core_mode_ff[csb_pkg::MODE_FIXED_ONE_BIT] <= 1'b1; // RULE_08
      core_mode_ff[csb_pkg::MODE_GEN_FLAG_BIT] <= bus_byte[csb_pkg::MODE_GEN_FLAG_BIT]; // RULE_12
    end
  end
  assign BAUD_SELECT_OUT = core_mode_ff[csb_pkg::MODE_BAUD_BIT]; // RULE_09
  assign EXT_MOVE_CODE_SPACE_OUT = core_mode_ff[csb_pkg::MODE_XMOVE_CODE_BIT]; // RULE_11
  assign GENERAL_FLAG_OUT = core_mode_ff[csb_pkg::MODE_GEN_FLAG_BIT];

  // Stored as written; software owns keeping bits 7 and 3 set
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      wait_ctrl_ff <= csb_pkg::RST_WAIT_CTRL; // RULE_14
    end else if (hit(csb_pkg::IDX_WAIT_CTRL)) begin
      wait_ctrl_ff <= bus_byte;
    end
  end
  assign PROG_WAIT_STATES_OUT =
    wait_ctrl_ff[csb_pkg::WAIT_PROG_LSB +: csb_pkg::WAIT_FIELD_W]; // RULE_15
  assign DATA_STRETCH_CYCLES_OUT =
    wait_ctrl_ff[csb_pkg::WAIT_DATA_LSB +: csb_pkg::WAIT_FIELD_W]; // RULE_16

  // Uses the wait fields as they stand when the instruction starts
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      duration_ff <= '0;
      duration_valid_ff <= 1'b0;
    end else begin
      duration_valid_ff <= INSTR_START_IN;
      if (INSTR_START_IN) begin
        duration_ff <= instr_duration(INSTR_DESC_IN, PROG_WAIT_STATES_OUT,
                                      DATA_STRETCH_CYCLES_OUT); // RULE_20
      end
    end
  end
  assign DURATION_OUT = duration_ff;
  assign DURATION_VALID_OUT = duration_valid_ff;

  // External trigger pins cross into the core clock before any use
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      ext_sync1_ff <= '0;
      ext_sync2_ff <= '0;
    end else begin
      ext_sync1_ff <= EXTERNAL_TRIG_IN;
      ext_sync2_ff <= ext_sync1_ff;
    end
  end

  // Test mode costs two extra cycles of latency through the synchroniser
  genvar gv;
  generate
    for (gv = 0; gv < csb_pkg::NUM_VECTORS; gv++) begin : g_vec
      always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
          vector_ff[gv] <= 1'b0;
        end else if (core_mode_ff[csb_pkg::MODE_INT_TEST_BIT]) begin
          vector_ff[gv] <= ext_sync2_ff[gv]; // RULE_10
        end else begin
          vector_ff[gv] <= INTERNAL_TRIG_IN[gv];
        end
      end
    end
  endgenerate
  assign VECTOR_TRIG_OUT = vector_ff;

  // Soft reset arming; PENDING means a 1 was written in the current instruction
  always_comb begin
    nxt_arm_state = arm_state_ff;
    case (arm_state_ff)
      csb_pkg::CSB_ARM_IDLE: begin
        // An end in the same cycle as the first write already closes that instruction
        if (soft_req_write && INSTR_END_IN) begin
          nxt_arm_state = csb_pkg::CSB_ARM_ARMED; // RULE_17
        end else if (soft_req_write) begin
          nxt_arm_state = csb_pkg::CSB_ARM_PENDING; // RULE_17
        end
      end
      csb_pkg::CSB_ARM_PENDING: begin
        if (INSTR_END_IN) begin
          nxt_arm_state = csb_pkg::CSB_ARM_ARMED;
        end
      end
      csb_pkg::CSB_ARM_ARMED: begin
        if (soft_req_write) begin
          nxt_arm_state = csb_pkg::CSB_ARM_IDLE; // RULE_18
        end else if (INSTR_END_IN) begin
          nxt_arm_state = csb_pkg::CSB_ARM_IDLE; // RULE_21
        end
      end
      default: nxt_arm_state = csb_pkg::CSB_ARM_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      arm_state_ff <= csb_pkg::CSB_ARM_IDLE;
    end else begin
      arm_state_ff <= nxt_arm_state;
    end
  end

  // One-cycle request; the reset generator is expected to answer with RESET_IN
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      soft_fire_ff <= 1'b0;
    end else begin
      soft_fire_ff <= (arm_state_ff == csb_pkg::CSB_ARM_ARMED) && soft_req_write; // RULE_18
    end
  end
  assign SOFT_RESET_OUT = soft_fire_ff;

  // Marks a fired request until the reset it asked for arrives
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      soft_fired_ff <= 1'b0;
    end else if (soft_fire_ff) begin
      soft_fired_ff <= 1'b1;
    end
  end

  // Source is kept through a reset of any length; a hardware cause always clears it.
  // Limitation: a later reset without a hardware cause keeps reporting software.
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      reset_src_ff <= !HW_RESET_CAUSE_IN
        && (soft_fire_ff || soft_fired_ff || reset_src_ff); // RULE_19
    end
  end

endmodule

/* test/csb_sfr_bank_sva.sv */
// Purpose: Concurrent checks on the register bank ports
// Assumes: Bus master holds each request until waitrequest is sampled low
// Notes: Read checks sample read data at the accepting edge
module csb_sfr_bank_sva (
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic [9:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic AVS_WAITREQUEST_OUT,
  input wire logic STACK_PUSH_IN,
  input wire logic STACK_POP_IN,
  input wire logic [7:0] STACK_PTR_OUT,
  input wire logic ACTIVE_DATA_POINTER_WRITE_IN,
  input wire logic [15:0] ACTIVE_DATA_POINTER_WDATA_IN,
  input wire logic [15:0] ACTIVE_ACTIVE_DATA_POINTER_OUT,
  input wire logic INSTR_START_IN,
  input wire csb_pkg::csb_instr_s INSTR_DESC_IN,
  input wire logic [csb_pkg::DUR_W-1:0] DURATION_OUT,
  input wire logic DURATION_VALID_OUT,
  input wire logic BAUD_SELECT_OUT,
  input wire logic EXT_MOVE_CODE_SPACE_OUT,
  input wire logic GENERAL_FLAG_OUT,
  input wire logic [2:0] PROG_WAIT_STATES_OUT,
  input wire logic [2:0] DATA_STRETCH_CYCLES_OUT,
  input wire logic SOFT_RESET_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  logic rd_ok;
  logic soft_reset_control_wr;
  logic [7:0] idx;
  logic [2:0] b;
  logic [7:0] exp_dur;
  assign rd_ok = AVS_READ_IN && !AVS_WAITREQUEST_OUT;
  assign idx = AVS_ADDRESS_IN[9:2];
  assign soft_reset_control_wr = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && idx == csb_pkg::IDX_SOFT_RESET
    && AVS_WRITEDATA_IN[0];
  // One-byte multi-cycle instructions still fetch two bytes
  assign b = (INSTR_DESC_IN.bytes > 3'h1 || INSTR_DESC_IN.cycles == 4'h1) ?
    INSTR_DESC_IN.bytes : 3'h2;
  assign exp_dur = 8'(INSTR_DESC_IN.cycles)
    + (8'(b) + 8'(INSTR_DESC_IN.is_code_move)) * 8'(PROG_WAIT_STATES_OUT)
    + 8'(INSTR_DESC_IN.is_ext_move) * 8'(DATA_STRETCH_CYCLES_OUT);
  a_bus_one_wait: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
    |=> !AVS_WAITREQUEST_OUT) else $error("bus wait longer than one cycle");
  a_push_incr: assert property (STACK_PUSH_IN && !STACK_POP_IN
    |=> STACK_PTR_OUT == $past(STACK_PTR_OUT) + 8'h01) else $error("push did not increment");
  a_pop_decr: assert property (STACK_POP_IN && !STACK_PUSH_IN
    |=> STACK_PTR_OUT == $past(STACK_PTR_OUT) - 8'h01) else $error("pop did not decrement");
  a_active_data_pointer_load: assert property (ACTIVE_DATA_POINTER_WRITE_IN && !AVS_WRITE_IN
    |=> ACTIVE_ACTIVE_DATA_POINTER_OUT == $past(ACTIVE_DATA_POINTER_WDATA_IN)) else $error("pointer load lost");
  a_mode_fixed: assert property (rd_ok && idx == csb_pkg::IDX_CORE_MODE
    |-> AVS_READDATA_OUT[6] == 1'b0 && AVS_READDATA_OUT[3] == 1'b1
    && AVS_READDATA_OUT[1:0] == 2'b00) else $error("mode fixed bits wrong");
  a_mode_fields: assert property (rd_ok && idx == csb_pkg::IDX_CORE_MODE
    |-> {AVS_READDATA_OUT[7], AVS_READDATA_OUT[4], AVS_READDATA_OUT[2]}
    == {BAUD_SELECT_OUT, EXT_MOVE_CODE_SPACE_OUT, GENERAL_FLAG_OUT})
    else $error("mode outputs differ from register");
  a_wait_fields: assert property (rd_ok && idx == csb_pkg::IDX_WAIT_CTRL
    |-> AVS_READDATA_OUT[6:4] == PROG_WAIT_STATES_OUT
    && AVS_READDATA_OUT[2:0] == DATA_STRETCH_CYCLES_OUT) else $error("wait outputs differ");
  a_duration_calc: assert property (INSTR_START_IN
    |=> DURATION_VALID_OUT && DURATION_OUT == $past(exp_dur)) else $error("duration wrong");
  a_soft_cause: assert property (SOFT_RESET_OUT |-> $past(soft_reset_control_wr))
    else $error("soft reset without write of one");
  a_soft_pulse: assert property (SOFT_RESET_OUT |=> !SOFT_RESET_OUT)
    else $error("soft reset pulse too long");
endmodule

bind csb_sfr_bank csb_sfr_bank_sva u_sva (.*);

/* test/csb_seq_model.sv */
// Purpose: Instruction sequencer stand-in driving the core strobes
// Assumes: Strobes change just after a rising edge and last one cycle
// Notes: Qualifying data is inverted once released so stale values never match
module csb_seq_model (
  input wire logic clk_in,
  output logic push_out,
  output logic pop_out,
  output logic end_out,
  output logic start_out,
  output logic dwr_out,
  output csb_pkg::csb_instr_s desc_out,
  output logic [15:0] dwdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] strb = 5'h00;
  assign push_out = strb[0];
  assign pop_out = strb[1];
  assign end_out = strb[2];
  assign start_out = strb[3];
  assign dwr_out = strb[4];
  initial desc_out = '0;
  initial dwdata_out = 16'h0000;
  task automatic fire(input logic [4:0] m, input csb_pkg::csb_instr_s d, input logic [15:0] w);
    @(posedge clk_in);
    strb <= m;
    desc_out <= d;
    dwdata_out <= w;
    @(posedge clk_in);
    strb <= 5'h00;
    desc_out <= ~d;
    dwdata_out <= ~w;
  endtask
endmodule

/* test/tb_top.sv */
// Purpose: Directed bench for the core register bank
// Assumes: Reset held twelve cycles, one bus request at a time
// Notes: Wait states are programmed to 5 and 2 before duration checks
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hw_cause = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] itrig = 4'h0;
  logic [3:0] etrig = 4'h0;
  logic [31:0] rdata, r;
  logic wait_req, push, pop, iend, istart, dwr, dur_v, baud, xcode, gflag, soft_reset_control;
  csb_pkg::csb_instr_s desc;
  logic [15:0] dwdata, active_data_pointer;
  logic [7:0] sp, dur;
  logic [2:0] pws, dsc;
  logic [3:0] vec;
  int mismatches = 0;
  int num_checks = 0;
  // Index, write value, expected read back
  localparam logic [23:0] TBL [9] = '{24'h81a5a5, 24'h823434, 24'h831212, 24'h84cdcd,
    24'h85abab, 24'h92ff01, 24'h87f4bc, 24'h8edada, 24'h805a00};
  localparam logic [8:0] DSC [4] = '{9'h044, 9'h048, 9'h0d2, 9'h049};
  localparam logic [7:0] DEXP [4] = '{8'h06, 8'h0c, 8'h15, 8'h11};
  always #12.5 clk = ~clk;
  csb_sfr_bank dut (.CLK_IN(clk), .RESET_IN(rst), .HW_RESET_CAUSE_IN(hw_cause),
    .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_BYTEENABLE_IN(4'h1),
    .AVS_WRITEDATA_IN(wdata), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_req),
    .STACK_PUSH_IN(push), .STACK_POP_IN(pop), .STACK_PTR_OUT(sp), .ACTIVE_DATA_POINTER_WRITE_IN(dwr),
    .ACTIVE_DATA_POINTER_WDATA_IN(dwdata), .ACTIVE_ACTIVE_DATA_POINTER_OUT(active_data_pointer), .INSTR_END_IN(iend),
    .INSTR_START_IN(istart), .INSTR_DESC_IN(desc), .DURATION_OUT(dur),
    .DURATION_VALID_OUT(dur_v), .BAUD_SELECT_OUT(baud), .EXT_MOVE_CODE_SPACE_OUT(xcode),
    .GENERAL_FLAG_OUT(gflag), .PROG_WAIT_STATES_OUT(pws), .DATA_STRETCH_CYCLES_OUT(dsc),
    .INTERNAL_TRIG_IN(itrig), .EXTERNAL_TRIG_IN(etrig), .VECTOR_TRIG_OUT(vec),
    .SOFT_RESET_OUT(soft_reset_control));
  csb_seq_model seq (.clk_in(clk), .push_out(push), .pop_out(pop), .end_out(iend),
    .start_out(istart), .dwr_out(dwr), .desc_out(desc), .dwdata_out(dwdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held from one rising edge until the rising edge that sees waitrequest low
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    if (wait_req !== 1'b0) mismatches++;
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    hw_cause <= 1'b0;
    bus(0, 8'h87, 8'h00);
    chk(r, 32'h08);
    bus(0, 8'h8e, 8'h00);
    chk(r, 32'h71);
    bus(0, 8'hf7, 8'h00);
    chk(r, 32'h00);
    // Mode write keeps bits 1:0 clear, wait write keeps bits 7 and 3 set
    for (int i = 0; i < 9; i++) bus(1, TBL[i][23:16], TBL[i][15:8]);
    for (int i = 0; i < 9; i++) begin
      bus(0, TBL[i][23:16], 8'h00);
      chk(r, {24'h0, TBL[i][7:0]});
    end
    chk({baud, xcode, gflag, pws, dsc}, {3'b111, 3'h5, 3'h2});
    chk(active_data_pointer, 16'habcd);
    bus(1, 8'h92, 8'h00);
    #1;
    chk(active_data_pointer, 16'h1234);
    for (int i = 0; i < 3; i++) begin
      seq.fire(5'(i + 1), '0, 16'h0);
      #1;
      chk(sp, i == 0 ? 8'ha6 : 8'ha5);
    end
    seq.fire(5'h10, '0, 16'hbeef);
    #1;
    chk(active_data_pointer, 16'hbeef);
    bus(0, 8'h82, 8'h00);
    chk(r, 32'hef);
    bus(0, 8'h83, 8'h00);
    chk(r, 32'hbe);
    for (int i = 0; i < 4; i++) begin
      seq.fire(5'h08, csb_pkg::csb_instr_s'(DSC[i]), 16'h0);
      #1;
      chk({dur_v, dur}, {1'b1, DEXP[i]});
    end
    @(posedge clk);
    itrig <= 4'hf;
    repeat (5) @(posedge clk);
    chk(vec, 4'h0);
    etrig <= 4'h5;
    repeat (5) @(posedge clk);
    chk(vec, 4'h5);
    bus(1, 8'h87, 8'h04);
    repeat (3) @(posedge clk);
    #1;
    chk(vec, 4'hf);
    bus(1, 8'hf7, 8'h01);
    #1;
    chk(soft_reset_control, 1'b0);
    seq.fire(5'h04, '0, 16'h0);
    seq.fire(5'h04, '0, 16'h0);
    bus(1, 8'hf7, 8'h01);
    #1;
    chk(soft_reset_control, 1'b0);
    seq.fire(5'h04, '0, 16'h0);
    bus(1, 8'hf7, 8'h01);
    #1;
    chk(soft_reset_control, 1'b1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(0, 8'hf7, 8'h00);
    chk(r, 32'h01);
    bus(0, 8'h87, 8'h00);
    chk(r, 32'h08);
    end_of_test();
  end
endmodule
